// ---- hdl/adcc_pkg.sv ----
// package: register map, field layout and converter interface types for the adc control block
package adcc_pkg;
    // register byte offsets on the axi4-lite slave
    localparam logic [3:0] ADCC_OFF_CSR   = 4'h0;
    localparam logic [3:0] ADCC_OFF_HIGH  = 4'h4;
    localparam logic [3:0] ADCC_OFF_LOW   = 4'h8;
    localparam int         ADCC_ADDR_W    = 4;

    // control/status bit positions
    localparam int ADCC_BIT_EOC   = 7;
    localparam int ADCC_BIT_SPEED = 6;
    localparam int ADCC_BIT_ON    = 5;
    localparam int ADCC_BIT_IE    = 4;
    localparam int ADCC_BIT_ONE   = 3;
    localparam int ADCC_CH_HI     = 2;
    localparam int ADCC_CH_LO     = 0;

    localparam logic [7:0] ADCC_CSR_RST  = 8'h00;
    localparam logic [9:0] ADCC_RES_RST  = 10'h000;
    localparam int         ADCC_RES_W    = 10;
    localparam int         ADCC_HIGH_LSB = 2;

    // converter clock division: speed 0 gives /2, speed 1 gives /4
    localparam logic [1:0] ADCC_DIV2_LAST = 2'h1;
    localparam logic [1:0] ADCC_DIV4_LAST = 2'h3;
    localparam logic [1:0] ADCC_DIV_RST   = 2'h0;

    // bits of conversion work in converter clock ticks (sample plus one per bit)
    localparam logic [3:0] ADCC_CONV_TICKS = 4'hb;
    localparam logic [3:0] ADCC_TICK_RST   = 4'h0;

    localparam logic [1:0] ADCC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ADCC_RESP_SLVERR = 2'h2;

    // request to the analog core
    typedef struct packed {
        logic       enable;    // core powered
        logic       start;     // one-cycle start pulse
        logic       clk_en;    // converter clock tick
        logic [2:0] channel;   // selected analog input
    } adcc_core_req_t;

    // answer from the analog core
    typedef struct packed {
        logic       done;      // end of conversion level, taken only at the block's own done
        logic [9:0] result;    // converted value
    } adcc_core_rsp_t;
endpackage

// ---- hdl/adcc_sar_seq.sv ----
// conversion sequencer: clock divider and conversion timing toward the analog core
`timescale 1ns/100ps
module adcc_sar_seq (
    input  wire logic       aclk,       // processor clock
    input  wire logic       aresetn,    // sync reset, active low
    input  wire logic       enable,     // converter on
    input  wire logic       restart,    // abort and restart the current conversion
    input  wire logic       speed,      // 0: /2, 1: /4
    output logic            tick_q,     // converter clock tick
    output logic            start_q,    // start pulse to the core
    output logic            done_q,     // end of conversion pulse
    output logic            busy_q      // conversion under way
);
    import adcc_pkg::*;

    logic [1:0] div_q;
    logic [3:0] cnt_q;
    logic       run_q;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn || !enable) begin
            div_q  <= ADCC_DIV_RST;
            tick_q <= 1'b0;
        end else if (div_q == (speed ? ADCC_DIV4_LAST : ADCC_DIV2_LAST)) begin
            div_q  <= ADCC_DIV_RST;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 2'h1;
            tick_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // start is taken as an arm request; counting happens on divided ticks
    always_ff @(posedge aclk) begin
        start_q <= 1'b0;
        done_q  <= 1'b0;
        if (!aresetn || !enable) begin
            run_q  <= 1'b0;
            busy_q <= 1'b0;
            cnt_q  <= ADCC_TICK_RST;
        end else if (restart || !run_q) begin
            run_q   <= 1'b1;
            busy_q  <= 1'b1;
            start_q <= 1'b1;
            cnt_q   <= ADCC_TICK_RST;
        end else if (busy_q && tick_q) begin
            if (cnt_q == ADCC_CONV_TICKS) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule

// ---- hdl/adcc_top.sv ----
// adc control, status and result registers behind an axi4-lite slave
`timescale 1ns/100ps
module adcc_top
    import adcc_pkg::*;
(
    input  wire logic                       aclk,          // processor clock, 50 MHz
    input  wire logic                       aresetn,       // sync reset, active low
    input  wire logic [ADCC_ADDR_W-1:0]     s_axi_awaddr,  // write address
    input  wire logic                       s_axi_awvalid, // write address valid
    output logic                            s_axi_awready, // write address ready
    input  wire logic [31:0]                s_axi_wdata,   // write data
    input  wire logic [3:0]                 s_axi_wstrb,   // write byte enables
    input  wire logic                       s_axi_wvalid,  // write data valid
    output logic                            s_axi_wready,  // write data ready
    output logic [1:0]                      s_axi_bresp,   // write response
    output logic                            s_axi_bvalid,  // write response valid
    input  wire logic                       s_axi_bready,  // write response ready
    input  wire logic [ADCC_ADDR_W-1:0]     s_axi_araddr,  // read address
    input  wire logic                       s_axi_arvalid, // read address valid
    output logic                            s_axi_arready, // read address ready
    output logic [31:0]                     s_axi_rdata,   // read data
    output logic [1:0]                      s_axi_rresp,   // read response
    output logic                            s_axi_rvalid,  // read data valid
    input  wire logic                       s_axi_rready,  // read data ready
    output adcc_pkg::adcc_core_req_t        core_req_q,    // request to analog core
    input  wire adcc_pkg::adcc_core_rsp_t   core_rsp,      // answer from analog core
    output logic                            irq_q          // interrupt request level
);
    import adcc_pkg::*;

    // csr fields
    logic       eoc_q;
    logic       speed_q;
    logic       on_q;
    logic       ie_q;
    logic       one_q;
    logic [2:0] ch_q;
    logic [9:0] res_q;
    logic       lock_q;

    // bus state
    logic                   aw_held_q;
    logic                   w_held_q;
    logic [ADCC_ADDR_W-1:0] awaddr_q;
    logic [31:0]            wdata_q;
    logic [3:0]             wstrb_q;

    // sequencer
    logic seq_tick;
    logic seq_start;
    logic seq_done;
    logic seq_busy;
    logic restart;
    logic sw_start;
    logic sw_conv_q;

    function automatic logic [1:0] adcc_resp(input logic [ADCC_ADDR_W-1:0] a);
        adcc_resp = (a == ADCC_OFF_CSR || a == ADCC_OFF_HIGH || a == ADCC_OFF_LOW)
                  ? ADCC_RESP_OKAY : ADCC_RESP_SLVERR;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order, one write at a time
    logic wr_fire;
    logic csr_wr;
    logic rd_fire;
    logic rd_high;
    logic rd_low;
    logic eoc_evt;
    logic [7:0] wbyte;

    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
    assign csr_wr  = wr_fire && (awaddr_q == ADCC_OFF_CSR) && wstrb_q[0];
    assign wbyte   = wdata_q[7:0];
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_high = rd_fire && (s_axi_araddr == ADCC_OFF_HIGH);
    assign rd_low  = rd_fire && (s_axi_araddr == ADCC_OFF_LOW);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            awaddr_q      <= '0;
            wdata_q       <= '0;
            wstrb_q       <= '0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= ADCC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q      <= s_axi_awaddr;
                aw_held_q     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                w_held_q     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= adcc_resp(awaddr_q);
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel: one read at a time, data registered with the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= ADCC_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= adcc_resp(s_axi_araddr);
            unique case (s_axi_araddr)
                ADCC_OFF_CSR:  s_axi_rdata <= {24'h000000, eoc_q, speed_q, on_q,
                                               ie_q, one_q, ch_q};
                ADCC_OFF_HIGH: s_axi_rdata <= {24'h000000,
                                               res_q[ADCC_RES_W-1:ADCC_HIGH_LSB]};
                ADCC_OFF_LOW:  s_axi_rdata <= {30'h00000000,
                                               res_q[ADCC_HIGH_LSB-1:0]};
                default:       s_axi_rdata <= '0;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control fields; the complete flag is never written by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {speed_q, ie_q, one_q, ch_q} <= '0;
        end else if (csr_wr) begin
            speed_q <= wbyte[ADCC_BIT_SPEED];
            ie_q    <= wbyte[ADCC_BIT_IE];
            one_q   <= wbyte[ADCC_BIT_ONE];
            ch_q    <= wbyte[ADCC_CH_HI:ADCC_CH_LO];
        end
    end

    // a software write wins over the hardware one-shot clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            on_q <= 1'b0;
        end else if (csr_wr) begin
            on_q <= wbyte[ADCC_BIT_ON];
        end else if (seq_done && one_q) begin
            on_q <= 1'b0;
        end
    end

    // abort on a changed channel, rearm on a fresh on=1 while idle, and rearm at every
    // end of conversion in continuous mode; a write of on=0 never restarts
    assign restart = (csr_wr && on_q && wbyte[ADCC_BIT_ON] &&
                      ((wbyte[ADCC_CH_HI:ADCC_CH_LO] != ch_q) || !seq_busy)) ||
                     (seq_done && !one_q && !csr_wr);
    assign sw_start = csr_wr && wbyte[ADCC_BIT_ON] && (!on_q || restart);

    // continuous rearms leave the flag standing until the high result is read;
    // only a conversion that software started holds it low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sw_conv_q <= 1'b0;
        end else if (sw_start) begin
            sw_conv_q <= 1'b1;
        end else if (seq_done || !on_q) begin
            sw_conv_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // completion flag: set wins over the high-result read clear
    assign eoc_evt = seq_done && core_rsp.done;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eoc_q <= 1'b0;
        end else if (eoc_evt) begin
            eoc_q <= 1'b1;
        end else if (sw_start || sw_conv_q || rd_high) begin
            eoc_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !on_q || rd_high) begin
            lock_q <= 1'b0;
        end else if (rd_low) begin
            lock_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res_q <= ADCC_RES_RST;
        end else if (eoc_evt && !lock_q) begin
            res_q <= core_rsp.result;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= eoc_q && ie_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // continuous mode: restart rearms the sequencer at each done while on stays set
    adcc_sar_seq u_seq (
        .aclk    (aclk),
        .aresetn (aresetn),
        .enable  (on_q),
        .restart (restart),
        .speed   (speed_q),
        .tick_q  (seq_tick),
        .start_q (seq_start),
        .done_q  (seq_done),
        .busy_q  (seq_busy)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_req_q <= '0;
        end else begin
            core_req_q.enable  <= on_q;
            core_req_q.start   <= seq_start;
            core_req_q.clk_en  <= seq_tick;
            core_req_q.channel <= ch_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_LOCK_HOLDS: assert property (@(posedge aclk) disable iff (!aresetn)
        lock_q && !rd_high && on_q |=> $stable(res_q))
        else $error("result changed while locked");
    AST_EOC_LOW_BUSY: assert property (@(posedge aclk) disable iff (!aresetn)
        sw_conv_q && !eoc_evt |=> !eoc_q)
        else $error("complete flag set during conversion");
    AST_EOC_SW_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
        sw_start && !eoc_evt |=> !eoc_q)
        else $error("complete flag kept at conversion start");
    AST_EOC_SETS: assert property (@(posedge aclk) disable iff (!aresetn)
        eoc_evt |=> eoc_q)
        else $error("complete flag not set");
    AST_EOC_HOLDS: assert property (@(posedge aclk) disable iff (!aresetn)
        eoc_q && !rd_high && !sw_start && !sw_conv_q |=> eoc_q)
        else $error("complete flag lost without high read");
    AST_FLAG_RO: assert property (@(posedge aclk) disable iff (!aresetn)
        csr_wr && !eoc_q && !eoc_evt |=> !eoc_q)
        else $error("software set the complete flag");
    AST_IRQ_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
        eoc_q && ie_q |=> irq_q)
        else $error("interrupt missing");
    AST_IRQ_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
        !eoc_q |=> !irq_q)
        else $error("interrupt without complete flag");
    AST_IRQ_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        !ie_q |=> !irq_q)
        else $error("interrupt without enable");
    AST_SINGLE_CONVERSION_SELECT_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_done && one_q && !csr_wr |=> !on_q)
        else $error("one-shot did not clear on");
    AST_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
        eoc_evt && !lock_q |=> res_q == $past(core_rsp.result))
        else $error("result not loaded");
    AST_HIGH_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_high && !eoc_evt |=> !eoc_q)
        else $error("high read did not clear flag");
    AST_HIGH_DATA: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_high |=> s_axi_rdata == {24'h000000, $past(res_q[ADCC_RES_W-1:ADCC_HIGH_LSB])})
        else $error("high result bits wrong");
    AST_LOW_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_low |=> s_axi_rdata[31:ADCC_HIGH_LSB] == '0)
        else $error("low result upper bits not zero");
    AST_LOW_DATA: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_low |=> s_axi_rdata[ADCC_HIGH_LSB-1:0] == $past(res_q[ADCC_HIGH_LSB-1:0]))
        else $error("low result bits wrong");
    AST_LOCK_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_low && on_q |=> lock_q)
        else $error("low read did not lock");
    AST_UNLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_high || !on_q |=> !lock_q)
        else $error("lock not released");
    AST_OFF_STOPS: assert property (@(posedge aclk) disable iff (!aresetn)
        !on_q |=> !seq_busy)
        else $error("conversion ran while off");
    AST_ON_START: assert property (@(posedge aclk) disable iff (!aresetn)
        csr_wr && !on_q && wbyte[ADCC_BIT_ON] |=> on_q ##1 seq_start)
        else $error("on write did not start a conversion");
    AST_CORE_ON: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> core_req_q.enable == $past(on_q))
        else $error("core enable does not follow on");
    AST_CONT_REARM: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_done && !one_q && on_q && !csr_wr |=> seq_busy && seq_start)
        else $error("continuous mode did not rearm");
    AST_RESTART_CH: assert property (@(posedge aclk) disable iff (!aresetn)
        csr_wr && on_q && wbyte[ADCC_BIT_ON] &&
        (wbyte[ADCC_CH_HI:ADCC_CH_LO] != ch_q) |=> seq_busy && seq_start)
        else $error("channel change did not restart");
    AST_CH_RW: assert property (@(posedge aclk) disable iff (!aresetn)
        csr_wr |=> ch_q == $past(wbyte[ADCC_CH_HI:ADCC_CH_LO]))
        else $error("channel field not written");
    AST_ONE_RW: assert property (@(posedge aclk) disable iff (!aresetn)
        csr_wr |=> one_q == $past(wbyte[ADCC_BIT_ONE]))
        else $error("mode bit not written");
    AST_IE_RW: assert property (@(posedge aclk) disable iff (!aresetn)
        csr_wr |=> ie_q == $past(wbyte[ADCC_BIT_IE]))
        else $error("interrupt enable not written");
    AST_SPEED_DIV: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_tick && speed_q && on_q ##1 on_q && speed_q |-> !seq_tick ##1 !seq_tick)
        else $error("divide by four broken");
    AST_DIV2: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_tick && !speed_q && on_q ##1 on_q && !speed_q |-> !seq_tick ##1 seq_tick)
        else $error("divide by two broken");
    AST_RESET_ZERO: assert property (@(posedge aclk) !aresetn |=>
        {eoc_q, speed_q, on_q, ie_q, one_q, ch_q} == ADCC_CSR_RST && res_q == ADCC_RES_RST)
        else $error("registers not cleared by reset");
endmodule

// ---- verif/adcc_core_model.sv ----
// analog core stand-in: takes channel and a start count at each start pulse
`timescale 1ns/100ps
module adcc_core_model (
    input  wire logic                     aclk,     // processor clock
    input  wire logic                     aresetn,  // sync reset, active low
    input  wire adcc_pkg::adcc_core_req_t req,      // request from the block
    output adcc_pkg::adcc_core_rsp_t      rsp,      // answer to the block
    output logic [6:0]                    starts_q  // starts seen so far
);
    import adcc_pkg::*;
    logic [2:0] ch_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            starts_q <= 7'h00;
            ch_q     <= 3'h0;
        end else if (req.start) begin
            starts_q <= starts_q + 7'h01;
            ch_q     <= req.channel;
        end
    end
    // done stands while powered: the block takes it only at its own end of conversion
    // a powered-down core shows the inverse so a stale result cannot pass for a fresh one
    always_comb begin
        rsp.done   = req.enable;
        rsp.result = req.enable ? {ch_q, starts_q} : ~{ch_q, starts_q};
    end
endmodule

// ---- verif/adc_control_result_regs_test.sv ----
// self-checking bench for the adc control and result registers
`timescale 1ns/100ps
module adc_control_result_regs_test;
    import adcc_pkg::*;
    logic           aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic           awready, wready, bvalid, arready, rvalid, irq;
    logic [3:0]     awaddr, araddr, wstrb;
    logic [31:0]    wdata, rdata;
    logic [1:0]     bresp, rresp;
    logic [6:0]     starts;
    adcc_core_req_t req;
    adcc_core_rsp_t rsp;
    int             fails, cmp_count;

    adcc_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .core_req_q(req), .core_rsp(rsp), .irq_q(irq));
    adcc_core_model i_core (.aclk(aclk), .aresetn(aresetn), .req(req), .rsp(rsp),
        .starts_q(starts));

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic hang();
        fails++;
        end_of_test();
    endtask
    // each bus task (wr, rd) starts one edge on, so no signal is assigned twice in a time step
    task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] resp);
        bit aw_ok, w_ok;
        aw_ok = 0;
        w_ok = 0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h000000, d};
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (awready === 1'b1 && !aw_ok) begin
                awvalid <= 1'b0;
                aw_ok = 1;
            end
            if (wready === 1'b1 && !w_ok) begin
                wvalid <= 1'b0;
                w_ok = 1;
            end
            if (bvalid === 1'b1) begin
                bready <= 1'b0;
                resp = bresp;
                return;
            end
        end
        hang();
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
        bit ar_ok;
        ar_ok = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (arready === 1'b1 && !ar_ok) begin
                arvalid <= 1'b0;
                ar_ok = 1;
            end
            if (rvalid === 1'b1) begin
                rready <= 1'b0;
                d = rdata;
                resp = rresp;
                return;
            end
        end
        hang();
    endtask
    task automatic wait_eoc(output logic [31:0] d);
        logic [1:0] r;
        for (int n = 0; n < 100; n++) begin
            rd(ADCC_OFF_CSR, d, r);
            if (d[7] === 1'b1) return;
        end
        hang();
    endtask
    task automatic tick_gap(output int g);
        g = 0;
        for (int n = 0; n < 20 && req.clk_en !== 1'b1; n++) @(posedge aclk);
        for (int n = 0; n < 20; n++) begin
            @(posedge aclk);
            g++;
            if (req.clk_en === 1'b1) break;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        rd(ADCC_OFF_CSR, d, r);
        chk("csr reset", d, 32'h0);
        rd(ADCC_OFF_HIGH, d, r);
        chk("high reset", d, 32'h0);
        rd(ADCC_OFF_LOW, d, r);
        chk("low reset", d, 32'h0);
        rd(4'hc, d, r);
        chk("unmapped read", r, ADCC_RESP_SLVERR);
        wr(4'hc, 8'hff, r);
        chk("unmapped write", r, ADCC_RESP_SLVERR);
        wr(ADCC_OFF_CSR, 8'hdf, r);
        chk("csr write resp", r, ADCC_RESP_OKAY);
        rd(ADCC_OFF_CSR, d, r);
        chk("csr rw", d, 32'h5f);
        chk("csr read resp", r, ADCC_RESP_OKAY);
        wr(ADCC_OFF_HIGH, 8'hff, r);
        rd(ADCC_OFF_HIGH, d, r);
        chk("high read only", d, 32'h0);
    endtask
    // one-shot per channel, divider switched every two channels, interrupt enable alternating
    task automatic t_single_conversion_select();
        logic [31:0] d;
        logic [1:0]  r;
        logic [9:0]  v;
        logic [7:0]  cfg;
        int          g;
        for (int c = 0; c < 8; c++) begin
            cfg = {1'b0, c[1], 1'b1, c[0], 1'b1, c[2:0]};
            wr(ADCC_OFF_CSR, cfg, r);
            tick_gap(g);
            chk("tick gap", g, c[1] ? 4 : 2);
            chk("channel", req.channel, c);
            wait_eoc(d);
            chk("csr done", d, {24'h0, cfg ^ 8'ha0});
            chk("irq set", irq, c[0]);
            v = {c[2:0], starts};
            rd(ADCC_OFF_LOW, d, r);
            chk("low", d, {30'h0, v[1:0]});
            rd(ADCC_OFF_HIGH, d, r);
            chk("high", d, {24'h0, v[9:2]});
            rd(ADCC_OFF_CSR, d, r);
            chk("flag cleared", d[7], 1'b0);
            chk("irq clear", irq, 1'b0);
        end
    endtask
    task automatic t_cont_lock();
        logic [31:0] d, lo, hi;
        logic [1:0]  r;
        logic [9:0]  v, w;
        logic [6:0]  s;
        wr(ADCC_OFF_CSR, 8'h22, r);
        wait_eoc(d);
        rd(ADCC_OFF_LOW, lo, r);
        repeat (150) @(posedge aclk);
        rd(ADCC_OFF_CSR, d, r);
        chk("still on", d[5], 1'b1);
        s = starts;
        rd(ADCC_OFF_HIGH, hi, r);
        v = {hi[7:0], lo[1:0]};
        chk("locked channel", v[9:7], 3'h2);
        chk("locked stale", (s - v[6:0]) >= 7'd3, 1'b1);
        repeat (60) @(posedge aclk);
        rd(ADCC_OFF_LOW, lo, r);
        rd(ADCC_OFF_HIGH, hi, r);
        w = {hi[7:0], lo[1:0]};
        chk("unlocked fresh", w[6:0] > v[6:0], 1'b1);
        wr(ADCC_OFF_CSR, 8'h02, r);
        // the core request is registered once more after the field update
        @(posedge aclk);
        chk("core off", req.enable, 1'b0);
        s = starts;
        repeat (100) @(posedge aclk);
        chk("stopped", starts, s);
    endtask
    // channel change mid-conversion restarts on the new input
    task automatic t_restart();
        logic [31:0] d;
        logic [1:0]  r;
        logic [6:0]  s;
        wr(ADCC_OFF_CSR, 8'h29, r);
        wait_eoc(d);
        wr(ADCC_OFF_CSR, 8'h29, r);
        rd(ADCC_OFF_CSR, d, r);
        chk("flag while busy", d[7], 1'b0);
        s = starts;
        wr(ADCC_OFF_CSR, 8'h2d, r);
        @(posedge aclk);
        chk("new channel", req.channel, 3'h5);
        repeat (3) @(posedge aclk);
        chk("restart", starts, s + 7'h01);
        wait_eoc(d);
        rd(ADCC_OFF_HIGH, d, r);
        chk("new result", d, {24'h0, 3'h5, starts[6:2]});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    initial begin
        fails = 0;
        cmp_count = 0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 4'h0;
        araddr = 4'h0;
        wstrb = 4'h0;
        wdata = 32'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_single_conversion_select();
        t_cont_lock();
        t_restart();
        end_of_test();
    end
endmodule
